//--- inc/iwd_pkg.sv
// Package of constants and types for the I/O port watchdog timer
// What this block does
// RQ1 - First port read enables the watchdog
// RQ2 - No refresh within timeout resets processor
// RQ3 - Writing zero disables the watchdog
// RQ4 - Expiry resets or interrupts per action
// RQ5 - Reset default action is processor reset
// RQ6 - Timeout nominal, tolerance thirty percent
// RQ7 - Writing one enables and restarts interval
// RQ8 - Counter clears on disable and reset
package iwd_pkg;
    // ---------------------------------------------------------------
    // Port map and data values
    // ---------------------------------------------------------------
    localparam logic [15:0] IWD_CTRL_PORT = 16'h0443;   // Control port address
    localparam logic [7:0] IWD_VAL_OFF = 8'h00;         // Disable value
    localparam logic [7:0] IWD_VAL_ON = 8'h01;          // Enable and refresh value
    localparam int IWD_EN_BIT = 0;                      // Read-back enable bit
    localparam int IWD_ACT_BIT = 1;                     // Read-back action bit
    localparam int IWD_EXP_BIT = 2;                     // Read-back expired bit
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam longint IWD_TIMEOUT_MS = 1600;           // Nominal timeout
    localparam longint IWD_CLK_HZ = 100_000_000;        // Clock rate
    localparam longint IWD_TIMEOUT_CYC = IWD_TIMEOUT_MS * IWD_CLK_HZ / 1000;
    localparam int IWD_PULSE_CYC = 16;                  // Pulse length on either action line
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic { IWD_ACT_RESET, IWD_ACT_IRQ } iwd_action_type;
    typedef struct packed
    {
        logic [15:0] addr;      // I/O address
        logic [7:0] wdata;      // Write data
        logic rd;               // Read strobe, one cycle
        logic wr;               // Write strobe, one cycle
    } iwd_io_type;
endpackage

//--- hdl/iwd_top.sv
// Watchdog timer reached through one I/O port
module iwd_top #(
    parameter longint TIMEOUT_CYC = iwd_pkg::IWD_TIMEOUT_CYC  // Timeout in cycles
) (
    input wire logic mclk,
    input wire logic reset_n,
    input iwd_pkg::iwd_io_type io_req,
    input wire logic action_irq,
    output logic [7:0] io_rdata,
    output logic cpu_reset,
    output logic wdt_irq
);
    // ---------------------------------------------------------------
    // Overview
    // ---------------------------------------------------------------
    // Host reads of the port arm the timer
    // Host writes of one arm it and restart the interval
    // Host writes of zero stop it and clear the count
    // Other ports and other data values leave it alone
    // On expiry a fixed-length pulse goes out on one of two lines
    // The action line is sampled every cycle into a register
    // After expiry the timer stays armed and counts again
    // Nominal interval is the package timeout count

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic enable_reg, enable_next;              // Timer running
    logic [31:0] count_reg, count_next;         // Elapsed cycles
    logic expired_reg, expired_next;            // Expiry seen
    logic [4:0] pulse_reg, pulse_next;          // Output pulse counter
    iwd_pkg::iwd_action_type act_reg, act_next; // Timeout action
    logic [7:0] rdata_reg, rdata_next;          // Read data
    logic hit;                                  // Address matches the port
    logic port_rd;                              // Read of the port this cycle
    logic port_wr;                              // Write of the port this cycle
    logic timeout;                              // Last cycle of the interval
    // Last count value before expiry, cut to the counter width
    localparam logic [31:0] LIMIT = 32'(TIMEOUT_CYC - 1); // RQ6

    // ---------------------------------------------------------------
    // Port decode
    // ---------------------------------------------------------------
    // Full sixteen-bit match, no aliases
    assign hit = (io_req.addr == iwd_pkg::IWD_CTRL_PORT);
    // Strobes qualified by the address
    assign port_rd = hit && io_req.rd;
    assign port_wr = hit && io_req.wr;
    // Interval ends when the count reaches its limit
    assign timeout = enable_reg && (count_reg == LIMIT);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        enable_next = enable_reg;
        count_next = count_reg;
        expired_next = expired_reg;
        pulse_next = pulse_reg;
        act_next = action_irq ? iwd_pkg::IWD_ACT_IRQ : iwd_pkg::IWD_ACT_RESET;
        rdata_next = rdata_reg;
        // Count while enabled
        if (enable_reg)
        begin
            count_next = count_reg + 32'h0000_0001;
        end
        // Expiry fires action and restarts interval
        if (timeout)
        begin
            expired_next = 1'b1;
            count_next = 32'h0000_0000;
            pulse_next = 5'(iwd_pkg::IWD_PULSE_CYC); // RQ2 RQ4
        end
        else if (pulse_reg != 5'h00)
        begin
            pulse_next = pulse_reg - 5'h01;
        end
        // Read enables the timer
        if (port_rd)
        begin
            enable_next = 1'b1; // RQ1
            rdata_next = 8'h00;
            rdata_next[iwd_pkg::IWD_EN_BIT] = enable_reg;
            rdata_next[iwd_pkg::IWD_ACT_BIT] = act_reg;
            rdata_next[iwd_pkg::IWD_EXP_BIT] = expired_reg;
            expired_next = timeout;
        end
        // Writes: one refreshes, zero disables
        if (port_wr && io_req.wdata == iwd_pkg::IWD_VAL_ON)
        begin
            enable_next = 1'b1;
            count_next = 32'h0000_0000; // RQ7
        end
        else if (port_wr && io_req.wdata == iwd_pkg::IWD_VAL_OFF)
        begin
            enable_next = 1'b0; // RQ3
            count_next = 32'h0000_0000; // RQ8
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Async reset returns every register to its idle value
    // Timer comes out of reset disarmed with the reset action
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enable_reg <= 1'b0;
            count_reg <= 32'h0000_0000; // RQ8
            expired_reg <= 1'b0;
            pulse_reg <= 5'h00;
            act_reg <= iwd_pkg::IWD_ACT_RESET; // RQ5
            rdata_reg <= 8'h00;
        end
        else
        begin
            enable_reg <= enable_next;
            count_reg <= count_next;
            expired_reg <= expired_next;
            pulse_reg <= pulse_next;
            act_reg <= act_next;
            rdata_reg <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Processor reset line, live while the pulse runs
    assign cpu_reset = (pulse_reg != 5'h00) && (act_reg == iwd_pkg::IWD_ACT_RESET); // RQ4
    // Interrupt line, live while the pulse runs
    assign wdt_irq = (pulse_reg != 5'h00) && (act_reg == iwd_pkg::IWD_ACT_IRQ);
    // Read data straight from its register
    assign io_rdata = rdata_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // A port read with no port write in the same cycle arms the timer
    read_enables_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ1
        port_rd && !port_wr |=> enable_reg)
        else $error("Read did not enable timer");

    // Expiry always starts a pulse
    expiry_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ2
        timeout && !port_wr |=> (cpu_reset || wdt_irq))
        else $error("Expiry gave no action");

    // Zero write stops and clears the timer
    off_disables_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ3
        port_wr && io_req.wdata == iwd_pkg::IWD_VAL_OFF |=> !enable_reg && count_reg == 0)
        else $error("Zero write did not disable");

    // Never both actions together
    action_sel_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ4
        !(cpu_reset && wdt_irq))
        else $error("Both actions at once");

    // Action low on the pin means reset action
    default_act_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ5
        $past(!action_irq) |-> act_reg == iwd_pkg::IWD_ACT_RESET)
        else $error("Default action not reset");

    // Expiry only after the counter stepped up to the limit from one below it
    no_early_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ6
        timeout |-> $past(enable_reg) && $past(count_reg) == LIMIT - 32'h0000_0001)
        else $error("Timeout before full interval");

    // Write of one arms and restarts
    refresh_restart_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ7
        port_wr && io_req.wdata == iwd_pkg::IWD_VAL_ON |=> enable_reg && count_reg == 0)
        else $error("Refresh did not restart");

    // Count stays at zero while disarmed
    idle_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ8
        !enable_reg && !$past(enable_reg) |-> count_reg == 0)
        else $error("Counter moved while disabled");

    // Expiry leaves the flag set
    expired_set_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ2
        timeout |=> expired_reg)
        else $error("Expiry flag not set");

    // Timer keeps running from zero after expiry
    expiry_rearm_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ2
        timeout && !port_wr |=> enable_reg && count_reg == 0)
        else $error("Timer not rearmed after expiry");

    // Read-back enable bit shows the state before the read
    read_back_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ1
        port_rd |=> io_rdata[iwd_pkg::IWD_EN_BIT] == $past(enable_reg))
        else $error("Read-back enable bit wrong");

    // Only a port read or a write of one arms the timer
    stray_access_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ1 RQ7
        !enable_reg && !port_rd && !(port_wr && io_req.wdata == iwd_pkg::IWD_VAL_ON)
        |=> !enable_reg)
        else $error("Timer armed without port access");

    // Disarmed timer never expires
    quiet_when_off_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ3
        !enable_reg |-> !timeout)
        else $error("Expiry while disabled");

    // Pulse counter never exceeds its length
    pulse_bound_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ4
        pulse_reg <= 5'(iwd_pkg::IWD_PULSE_CYC))
        else $error("Pulse counter out of range");

    // Pulse counts down one step a cycle
    pulse_step_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ4
        pulse_reg != 5'h00 && !timeout |=> pulse_reg == $past(pulse_reg) - 5'h01)
        else $error("Pulse counter skipped");

    // Interrupt only under the interrupt action
    irq_path_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ4
        wdt_irq |-> act_reg == iwd_pkg::IWD_ACT_IRQ)
        else $error("Interrupt under reset action");

    // Processor reset only under the reset action
    reset_path_a: assert property (@(posedge mclk) disable iff (!reset_n) // RQ5
        cpu_reset |-> act_reg == iwd_pkg::IWD_ACT_RESET)
        else $error("Processor reset under interrupt action");
endmodule

//--- bench/iwd_host.sv
// Host model issuing single-byte I/O port accesses
module iwd_host (
    input wire logic mclk,
    output iwd_pkg::iwd_io_type io_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus: no strobes
    initial io_req = '0;
    // One access: strobe held for exactly one edge
    task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d);
    begin
        @(posedge mclk);
        #1;
        io_req = '{addr: a, wdata: d, rd: rd, wr: !rd};
        @(posedge mclk);
        #1;
        io_req = '0;
    end
    endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the port watchdog
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 50; // Shortened timeout
    localparam logic [15:0] P = iwd_pkg::IWD_CTRL_PORT;
    logic mclk = 0, reset_n = 0, action_irq = 0;
    iwd_pkg::iwd_io_type io_req;
    logic [7:0] io_rdata;
    logic cpu_reset, wdt_irq;
    int miscompares = 0, cmp_count = 0, cyc = 0, seed = 85, en = 0, act = 0, ex = 0, i;
    integer nr, ni;
    iwd_top #(.TIMEOUT_CYC(T)) uut (.mclk(mclk), .reset_n(reset_n), .io_req(io_req),
        .action_irq(action_irq), .io_rdata(io_rdata), .cpu_reset(cpu_reset),
        .wdt_irq(wdt_irq));
    iwd_host host (.mclk(mclk), .io_req(io_req));
    // Clock and hang guard
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc > 2000) begin miscompares++; wrap_up(); end
    // Closing report
    task automatic wrap_up();
        $display("Errors %0d of %0d checks", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Port write, model follows
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host.acc(0, a, d);
        if (a == P && d == 8'h01) en = 1;
        if (a == P && d == 8'h00) en = 0;
    endtask
    // Port read and read-back compare
    task automatic rd();
        host.acc(1, P, 8'h00);
        @(posedge mclk);
        #1;
        `CHK("io_rdata", (ex << 2) | (act << 1) | en, io_rdata)
        en = 1;
        ex = 0;
    endtask
    // Count pulse cycles over a window
    task automatic watch(input int n);
        nr = 0;
        ni = 0;
        repeat (n) begin @(posedge mclk); #2; nr = nr + cpu_reset; ni = ni + wdt_irq; end
        `CHK("cpu_reset", (en && n > T && !act) ? 16 : 0, nr)
        `CHK("wdt_irq", (en && n > T && act) ? 16 : 0, ni)
        if (en && n > T) ex = 1;
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        #1 reset_n = 1;
        rd();
        watch(T + 20);
        rd();
        wr(P, 8'h00);
        watch(2 * T);
        for (i = 0; i < 4; i++) wr(P ^ (16'($random(seed)) | 16'h0001), 8'h01);
        watch(T + 20);
        for (i = 0; i < 5; i++) begin wr(P, 8'h01); watch(i < 4 ? T / 2 : T + 20); end
        rd();
        wr(P, 8'h00);
        action_irq = 1;
        act = 1;
        wr(P, 8'h01);
        wr(P, 8'($random(seed)) | 8'h02);
        watch(T + 20);
        rd();
        // Mid-run reset: action back to reset, timer off
        reset_n = 0;
        action_irq = 0;
        act = 0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1;
        en = 0;
        ex = 0;
        rd();
        watch(T + 20);
        rd();
        wrap_up();
    end
endmodule
